// *** logic/bus_fabric_pkg.sv ***
// Shared constants for the single-initiator bus fabric
package bus_fabric_pkg;
   localparam int DATA_W_DEFAULT = 32;
   localparam int ADDR_W = 32;
   localparam int SLAVES_DEFAULT = 3;
   // Region decode: upper address bits pick the target
   localparam int REGION_LSB = 28;
   localparam int REGION_W = 4;
   localparam logic [1:0] TRANS_IDLE = 2'h0;
   localparam logic [1:0] TRANS_BUSY = 2'h1;
   localparam logic [1:0] TRANS_NONSEQ = 2'h2;
   localparam logic [1:0] TRANS_SEQ = 2'h3;
   localparam logic [2:0] BURST_SINGLE = 3'h0;
   localparam logic [2:0] BURST_INCR = 3'h1;
   localparam logic [2:0] BURST_WRAP4 = 3'h2;
   localparam logic [2:0] BURST_INCR4 = 3'h3;
   localparam logic RESP_OKAY = 1'h0;
   localparam logic RESP_ERROR = 1'h1;
   // Optional capabilities not declared are absent
   localparam logic CAP_SECURE = 1'h0;
   localparam logic CAP_EXCLUSIVE = 1'h0;
   localparam logic CAP_EXT_MEM_TYPES = 1'h0;
endpackage : bus_fabric_pkg

// *** logic/bus_fabric_if.sv ***
// Interface joining the fabric to the initiator and to the targets
`timescale 1ns/1ns
`default_nettype none
interface bus_fabric_if #(
   parameter int DATA_W = 32,
   parameter int SLAVES = 3
) (
   input wire logic i_core_clk
);
   logic i_rst;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [2:0] hburst;
   logic [DATA_W-1:0] hwdata;
   logic [DATA_W-1:0] hrdata;
   logic hready;
   logic hresp;
   logic [SLAVES-1:0] hsel;
   logic [SLAVES-1:0] s_hreadyout;
   logic [SLAVES-1:0] s_hresp;
   logic [SLAVES*DATA_W-1:0] s_hrdata;

   modport fabric (
      input i_core_clk, i_rst, haddr, htrans, hwrite, hsize, hburst,
      hwdata, s_hreadyout, s_hresp, s_hrdata,
      output hrdata, hready, hresp, hsel
   );
   modport initiator (
      input i_core_clk, i_rst, hrdata, hready, hresp,
      output haddr, htrans, hwrite, hsize, hburst, hwdata
   );
endinterface : bus_fabric_if
`default_nettype wire

// *** logic/bus_fabric.sv ***
// Address decoder and target-to-initiator return multiplexor
// Limitation: targets sit in the top address nibble, one region each,
// so at most sixteen targets can be reached.
`timescale 1ns/1ns
`default_nettype none
module bus_fabric
   import bus_fabric_pkg::*;
#(
   parameter int DATA_W = DATA_W_DEFAULT,
   parameter int SLAVES = SLAVES_DEFAULT
) (
   bus_fabric_if.fabric bus,
   output logic o_decode_miss
);
   ////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [SLAVES-1:0] dsel;
      logic dmiss;
      logic err_second;
      logic miss_flag;
   } state_t;

   state_t state_reg;
   state_t state_next;
   logic [SLAVES-1:0] asel;
   logic amiss;
   logic active;
   logic rdy;
   logic [DATA_W-1:0] rd_mux;
   logic rdy_mux;
   logic resp_mux;

   ////////////////////////////////////////////////////////////////////
   // decode address
   for (genvar g = 0; g < SLAVES; g++) begin : gen_decode
      assign asel[g] = (bus.haddr[REGION_LSB +: REGION_W] == REGION_W'(g));
   end
   // Unmapped regions fall to the built-in error responder
   assign amiss = ~|asel;

   // secure, exclusive and extended types absent
   logic caps_absent;
   assign caps_absent = ~(CAP_SECURE | CAP_EXCLUSIVE | CAP_EXT_MEM_TYPES);

   // select is combinational during the single address cycle
   assign bus.hsel = asel;
   assign active = bus.htrans[1];

   ////////////////////////////////////////////////////////////////////
   // return multiplexor, single instance
   always_comb begin
      rd_mux = '0;
      rdy_mux = 1'b1;
      resp_mux = RESP_OKAY;
      for (int i = 0; i < SLAVES; i++) begin
         if (state_reg.dsel[i]) begin
            rd_mux = bus.s_hrdata[i*DATA_W +: DATA_W];
            rdy_mux = bus.s_hreadyout[i];
            resp_mux = bus.s_hresp[i];
         end
      end
      // Unmapped data phase: two-cycle error so the initiator can cancel
      if (state_reg.dmiss) begin
         rdy_mux = state_reg.err_second;
         resp_mux = RESP_ERROR;
      end
   end

   assign rdy = rdy_mux;
   assign bus.hrdata = rd_mux;
   assign bus.hready = rdy;
   assign bus.hresp = resp_mux;

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      if (state_reg.dmiss) begin
         state_next.err_second = 1'b1;
      end
      // capture select when ready high, hold during waits
      if (rdy) begin
         state_next.dsel = active ? asel : '0;
         state_next.dmiss = active & amiss;
         state_next.err_second = 1'b0;
         if (active & amiss) begin
            state_next.miss_flag = 1'b1;
         end
      end
   end

   always_ff @(posedge bus.i_core_clk) begin
      if (bus.i_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_decode_miss = state_reg.miss_flag;
endmodule : bus_fabric
`default_nettype wire

// *** logic/bus_initiator.sv ***
// Simple initiator end issuing single transfers onto the fabric
`timescale 1ns/1ns
`default_nettype none
module bus_initiator
   import bus_fabric_pkg::*;
#(
   parameter int DATA_W = DATA_W_DEFAULT
) (
   bus_fabric_if.initiator bus,
   input wire logic i_req,
   input wire logic i_write,
   input wire logic [31:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   output logic o_busy,
   output logic o_done,
   output logic o_error,
   output logic [DATA_W-1:0] o_rdata
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ADDR = 2'b01,
      ST_DATA = 2'b10
   } phase_t;
   typedef struct packed {
      phase_t ph;
      logic [31:0] addr;
      logic wr;
      logic [DATA_W-1:0] wdata;
      logic done;
      logic err;
      logic [DATA_W-1:0] rdata;
   } state_t;
   state_t state_reg;
   state_t state_next;

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      state_next.done = 1'b0;
      case (state_reg.ph)
         ST_IDLE: begin
            if (i_req) begin
               state_next.ph = ST_ADDR;
               state_next.addr = i_addr;
               state_next.wr = i_write;
               state_next.wdata = i_wdata;
            end
         end
         // one address cycle when ready high
         ST_ADDR: begin
            if (bus.hready) begin
               state_next.ph = ST_DATA;
            end
         end
         ST_DATA: begin
            if (bus.hready) begin
               state_next.ph = ST_IDLE;
               state_next.done = 1'b1;
               state_next.err = bus.hresp;
               if (!state_reg.wr) begin
                  state_next.rdata = bus.hrdata;
               end
            end
         end
         default: state_next.ph = ST_IDLE;
      endcase
   end

   always_ff @(posedge bus.i_core_clk) begin
      if (bus.i_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // address and control; single transfers used here
   assign bus.haddr = state_reg.addr;
   assign bus.htrans = (state_reg.ph == ST_ADDR) ? TRANS_NONSEQ : TRANS_IDLE;
   assign bus.hwrite = state_reg.wr;
   assign bus.hsize = 3'h2;
   assign bus.hburst = BURST_SINGLE;
   // write data driven from the captured value in every phase
   assign bus.hwdata = state_reg.wdata;
   assign o_busy = (state_reg.ph != ST_IDLE);
   assign o_done = state_reg.done;
   assign o_error = state_reg.err;
   assign o_rdata = state_reg.rdata;
endmodule : bus_initiator
`default_nettype wire

// *** tb/bus_fabric_assertions.sv ***
// Checker on the shared bus between fabric, initiator and targets
`timescale 1ns/1ns
`default_nettype none
module bus_fabric_assertions
   import bus_fabric_pkg::*;
#(
   parameter int SLAVES = 3
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic hresp,
   input wire logic [SLAVES-1:0] hsel,
   input wire logic [SLAVES-1:0] s_hreadyout,
   input wire logic [SLAVES-1:0] s_hresp
);
   // Own data-phase owner, so a stale mux select shows up
   logic dv_reg;
   logic [3:0] dk_reg;
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         dv_reg <= 1'b0;
         dk_reg <= 4'h0;
      end else if (hready) begin
         dv_reg <= htrans[1];
         dk_reg <= haddr[31:28];
      end
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   sequence err_two;
      hresp ##1 (hready && hresp);
   endsequence
   //////////////////////////////////////////////////////////////////
   chk_sel_onehot: assert property ($onehot0(hsel))
      else $error("several targets selected");
   chk_sel_decode: assert property (
      htrans[1] && haddr[31:28] < SLAVES |-> hsel[haddr[31:28]])
      else $error("addressed target not selected");
   chk_ready_mux: assert property (
      dv_reg && dk_reg < SLAVES |-> hready == s_hreadyout[dk_reg])
      else $error("ready from wrong target");
   chk_resp_mux: assert property (
      dv_reg && dk_reg < SLAVES |-> hresp == s_hresp[dk_reg])
      else $error("response from wrong target");
   chk_idle_ready: assert property (!dv_reg |-> hready && !hresp)
      else $error("ready low outside data phase");
   chk_miss_error: assert property (
      dv_reg && dk_reg >= SLAVES && !hready |-> err_two)
      else $error("unmapped error not two cycles");
   chk_addr_hold: assert property (
      htrans[1] && !hready |=> $stable(haddr) && $stable(htrans))
      else $error("address moved in wait state");
   chk_reset_idle: assert property (
      $fell(i_rst) |-> htrans == TRANS_IDLE && hready)
      else $error("bus not idle after reset");
   chk_wait_bound: assert property (!hready |-> ##[1:20] hready)
      else $error("wait state never ended");
endmodule : bus_fabric_assertions
`default_nettype wire

// *** tb/testbench.sv ***
// Bench: initiator stimulus, target models and scoreboard
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam int DW = 32;
   localparam int NS = 3;
   logic i_core_clk = 1'b0;
   logic req = 1'b0;
   logic wr = 1'b0;
   logic [31:0] addr = '0;
   logic [DW-1:0] wdata = '0;
   logic busy, done, err, miss;
   logic [DW-1:0] rdata;
   logic tv = 1'b0;
   logic tw = 1'b0;
   logic [31:0] ta = '0;
   logic [DW-1:0] rd;
   logic seen_miss = 1'b0;
   int fail_count = 0;
   int samples_checked = 0;
   int seed;
   logic [DW-1:0] mem [logic [31:0]];
   logic [DW-1:0] ref_mem [logic [31:0]];
   bus_fabric_if #(.DATA_W(DW), .SLAVES(NS)) bus (.i_core_clk(i_core_clk));
   bus_fabric #(.DATA_W(DW), .SLAVES(NS)) bus_fabric_inst (.bus(bus),
      .o_decode_miss(miss));
   bus_initiator #(.DATA_W(DW)) bus_initiator_inst (.bus(bus), .i_req(req),
      .i_write(wr), .i_addr(addr), .i_wdata(wdata), .o_busy(busy),
      .o_done(done), .o_error(err), .o_rdata(rdata));
   bus_fabric_assertions #(.SLAVES(NS)) chk_inst (.i_core_clk(i_core_clk),
      .i_rst(bus.i_rst), .haddr(bus.haddr), .htrans(bus.htrans),
      .hready(bus.hready), .hresp(bus.hresp), .hsel(bus.hsel),
      .s_hreadyout(bus.s_hreadyout), .s_hresp(bus.s_hresp));
   initial begin
      forever #2 i_core_clk = ~i_core_clk;
   end
   //////////////////////////////////////////////////////////////////
   // Targets: memory with random waits; unselected slices carry ~data
   always @(posedge i_core_clk) begin
      if (bus.hready) begin
         if (tv && tw && ta[31:28] < NS) mem[ta] = bus.hwdata;
         tv <= bus.htrans[1] && (|bus.hsel);
         tw <= bus.hwrite;
         ta <= bus.haddr;
      end
   end
   always @(negedge i_core_clk) begin
      rd = mem.exists(ta) ? mem[ta] : ~ta;
      // Idle targets show noise, so a wrong mux select is caught
      bus.s_hreadyout <= NS'($urandom);
      bus.s_hresp <= NS'($urandom);
      if (tv && ta[31:28] < NS) begin
         bus.s_hreadyout[ta[31:28]] <= $urandom % 3 != 0;
         bus.s_hresp[ta[31:28]] <= 1'b0;
      end
      for (int j = 0; j < NS; j++) bus.s_hrdata[j*DW +: DW] <= j == ta[31:28] ? rd : ~rd;
   end
   task automatic chk(input logic [DW-1:0] s, input logic [DW-1:0] e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %0t saw %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic results();
      if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task automatic xfer(input logic w, input logic [31:0] a,
                       input logic [DW-1:0] d);
      logic bad;
      int n;
      bad = a[31:28] >= NS;
      req = 1'b1;
      wr = w;
      addr = a;
      wdata = d;
      @(negedge i_core_clk);
      req = 1'b0;
      n = 0;
      do begin
         @(posedge i_core_clk);
         #1 n++;
      end while (done !== 1'b1 && n < 40);
      seen_miss = seen_miss | bad;
      if (!bad && w) ref_mem[a] = d;
      chk(done, 1'b1);
      chk(err, bad);
      chk(miss, seen_miss);
      if (!w && !bad) chk(rdata, ref_mem.exists(a) ? ref_mem[a] : ~a);
      @(negedge i_core_clk);
   endtask : xfer
   initial begin
      bus.i_rst = 1'b1;
      bus.s_hreadyout = '1;
      bus.s_hresp = '0;
      bus.s_hrdata = '0;
      seed = $urandom(32'h8fa2806d);
      repeat (12) @(negedge i_core_clk);
      bus.i_rst = 1'b0;
      for (int i = 0; i < 90; i++) begin
         xfer(1'($urandom), {4'($urandom % 4), 24'h0, 2'($urandom), 2'h0},
            $urandom);
      end
      bus.i_rst = 1'b1;
      repeat (2) @(negedge i_core_clk);
      chk(miss, 1'b0);
      chk(busy, 1'b0);
      seen_miss = 1'b0;
      bus.i_rst = 1'b0;
      xfer(1'b0, 32'h1000_0004, '0);
      results();
   end
   initial begin
      #20000;
      fail_count++;
      results();
   end
endmodule : testbench
`default_nettype wire
